//--- design/crf_rx_framer.sv
// Purpose: Receive collision handling, bit framing and modem sequencing
// Assumes: Symbols, bit tick and CRC check come from same-clock logic
// Notes: Transmit framing and CRC arithmetic sit outside this block
`timescale 1ns/1ns
`include "crf_cfg.svh"
module crf_rx_framer
	import crf_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic bit_tick_in,
	input wire logic cmd_valid_in,
	input wire logic [5:0] cmd_code_in,
	input wire crf_cfg_t cfg_in,
	input wire logic [7:0] tx_bits_in,
	input wire logic align_load_in,
	input wire logic [2:0] align_value_in,
	input wire crf_sym_t sym_in,
	input wire logic crc_ok_in,
	output logic fifo_wr_out,
	output logic [7:0] fifo_data_out,
	output logic rx_done_out,
	output crf_err_t err_out,
	output logic [7:0] collision_position_out,
	output logic [2:0] last_byte_valid_bits_out,
	output logic [2:0] receive_alignment_offset_out,
	output logic [2:0] modem_state_field_out,
	output logic rx_sample_tick_out
);
	// Whole register state of the framer
	typedef struct packed {
		crf_state_t fsm;
		logic [7:0] tx_cnt;
		logic [3:0] bitn;
		logic [7:0] shreg;
		logic par_acc;
		logic expect_parity;
		logic first_parity;
		logic first_byte;
		logic sof_fault;
		logic collided;
		logic [7:0] pos_cnt;
		logic [7:0] coll_pos;
		logic [7:0] byte_cnt;
		logic [2:0] align;
		logic [2:0] last_bits;
		crf_err_t err;
		logic wr;
		logic [7:0] wr_data;
		logic done;
	} crf_st_t;

	// Present and next copies
	crf_st_t st;
	crf_st_t next_st;
	// Counter and decode helpers
	logic wait_load;
	logic wait_done;
	logic [3:0] weak_amp;
	logic sym_coll;
	logic sym_bit;
	logic data_bit;
	logic [7:0] byte_now;
	logic parity_want;
	logic [7:0] crc_min;

	// ==========================================
	// Receive wait and phase counters
	assign wait_load = (st.fsm == CRF_GO_RX_START) && bit_tick_in;
	crf_countdown #(.WIDTH(8)) u_rx_wait (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.load_in(wait_load),
		.value_in(cfg_in.receive_wait_delay),
		.tick_in(bit_tick_in),
		.done_out(wait_done)
	);
	crf_countdown #(.WIDTH(4)) u_phase (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.load_in(bit_tick_in),
		.value_in(cfg_in.tx_rx_phase_setting),
		.tick_in(1'b1),
		.done_out(rx_sample_tick_out)
	);

	// ==========================================
	// Symbol decode: weaker half against threshold
	always_comb
	begin
		weak_amp = (sym_in.amp_first < sym_in.amp_second) ? sym_in.amp_first : sym_in.amp_second;
		sym_coll = (weak_amp > cfg_in.collision_level_threshold);
		sym_bit = sym_coll ? 1'b1 : (sym_in.amp_first > sym_in.amp_second);
		// Bits after the first collision forced low
		if (cfg_in.zero_after_collision_option && st.collided)
			data_bit = 1'b0;
		else
			data_bit = sym_bit;
		byte_now = st.shreg;
		byte_now[st.bitn[2:0]] = data_bit;
		// Parity target from accumulated data bits
		parity_want = cfg_in.odd_parity_select ? ~st.par_acc : st.par_acc;
		// Shortest frame holding the CRC block
		crc_min = cfg_in.crc_two_bytes ? 8'h02 : 8'h01;
	end

	// ==========================================
	// Sequencer and receive framing
	always_comb
	begin
		next_st = st;
		next_st.wr = 1'b0;
		next_st.done = 1'b0;
		// Idle command aborts anything running
		if (cmd_valid_in && (cmd_code_in == `CRF_CMD_IDLE))
			next_st.fsm = CRF_IDLE;
		else
		begin
			case (st.fsm)

				// Wait for the host to start
				CRF_IDLE:
				begin
					// Started only by host command
					if (cmd_valid_in && (cmd_code_in == `CRF_CMD_TRANSCEIVE))
					begin
						next_st.fsm = CRF_TX_SOF;
						next_st.tx_cnt = `CRF_SOF_TICKS;
						next_st.err = '0;
						next_st.collided = 1'b0;
						next_st.coll_pos = '0;
						next_st.last_bits = '0;
					end
				end

				// Start-of-frame transmit phase
				CRF_TX_SOF:
				begin
					if (bit_tick_in)
					begin
						next_st.tx_cnt = st.tx_cnt - 8'h01;
						if (st.tx_cnt == 8'h01)
						begin
							next_st.fsm = CRF_TX_DATA;
							next_st.tx_cnt = tx_bits_in;
						end
					end
				end

				// Payload bit ticks
				CRF_TX_DATA:
				begin
					if (bit_tick_in)
					begin
						next_st.tx_cnt = st.tx_cnt - 8'h01;
						if (st.tx_cnt <= 8'h01)
						begin
							next_st.fsm = CRF_TX_EOF;
							next_st.tx_cnt = `CRF_EOF_TICKS;
						end
					end
				end

				// End-of-frame transmit phase
				CRF_TX_EOF:
				begin
					if (bit_tick_in)
					begin
						next_st.tx_cnt = st.tx_cnt - 8'h01;
						if (st.tx_cnt == 8'h01)
							next_st.fsm = CRF_GO_RX_START;
					end
				end

				// Receiver start transition
				CRF_GO_RX_START:
				begin
					if (bit_tick_in)
						next_st.fsm = CRF_RX_DELAY;
				end

				// Receive wait running
				CRF_RX_DELAY:
				begin
					if (wait_done)
						next_st.fsm = CRF_AWAIT;
				end

				// First symbol must be a start
				CRF_AWAIT:
				begin
					if (sym_in.valid)
					begin
						next_st.fsm = CRF_RECEIVING;
						next_st.bitn = {1'b0, st.align};
						next_st.pos_cnt = {5'h00, st.align};
						next_st.shreg = '0;
						next_st.par_acc = 1'b0;
						next_st.expect_parity = 1'b0;
						next_st.first_parity = 1'b1;
						next_st.first_byte = 1'b1;
						next_st.byte_cnt = '0;
						next_st.sof_fault = 1'b0;
						if (!sym_in.is_sof)
						begin
							next_st.err.framing_error_flag = 1'b1;
							next_st.sof_fault = 1'b1;
						end
						else if (sym_coll)
						begin
							next_st.err.framing_error_flag = 1'b1;
							next_st.err.collision_error_flag = 1'b1;
							next_st.collided = 1'b1;
							next_st.coll_pos = `CRF_SOF_POSITION;
							next_st.sof_fault = 1'b1;
						end
						// End at once on a lone start symbol
						if (sym_in.end_of_stream)
							next_st.fsm = CRF_GO_RX_FINISH;
					end
				end

				// Data and parity symbols
				CRF_RECEIVING:
				begin
					if (sym_in.valid && !sym_in.end_of_stream && !st.sof_fault)
					begin
						if (sym_coll)
							next_st.err.collision_error_flag = 1'b1;
						if (st.expect_parity)
						begin
							// Parity slot, not counted in position
							next_st.expect_parity = 1'b0;
							next_st.first_parity = 1'b0;
							next_st.par_acc = 1'b0;
							if (sym_coll)
								next_st.err.parity_error_flag = 1'b1;
							else if ((st.first_parity && (st.align != 3'h0)) ||
								(cfg_in.zero_after_collision_option && st.collided))
								next_st.err.parity_error_flag = st.err.parity_error_flag;
							else if (sym_bit != parity_want)
								next_st.err.parity_error_flag = 1'b1;
						end
						else
						begin
							next_st.pos_cnt = st.pos_cnt + 8'h01;
							if (sym_coll && !st.collided)
							begin
								next_st.collided = 1'b1;
								next_st.coll_pos = st.pos_cnt + 8'h01;
							end
							next_st.par_acc = st.par_acc ^ data_bit;
							next_st.shreg = byte_now;
							next_st.bitn = st.bitn + 4'h1;
							if (st.bitn == 4'h7)
							begin
								// Byte complete, forward it unless it is the first byte under alignment 7
								next_st.bitn = 4'h0;
								next_st.shreg = '0;
								next_st.first_byte = 1'b0;
								next_st.expect_parity = cfg_in.parity_enable;
								if (!(st.first_byte && (st.align == `CRF_ALIGN_SUPPRESS)))
								begin
									next_st.wr = 1'b1;
									next_st.wr_data = byte_now;
									next_st.byte_cnt = (st.byte_cnt == 8'hff) ? st.byte_cnt : st.byte_cnt + 8'h01;
								end
							end
						end
					end
					// End symbol closes the frame
					if (sym_in.valid && sym_in.end_of_stream)
						next_st.fsm = CRF_GO_RX_FINISH;
				end

				// Receiver finish transition
				CRF_GO_RX_FINISH:
				begin
					next_st.fsm = CRF_IDLE;
					next_st.done = 1'b1;
					next_st.align = `CRF_ALIGN_RESET;
					next_st.last_bits = st.bitn[2:0];
					// Flush the partial last byte
					if (!st.sof_fault && (st.bitn != 4'h0))
					begin
						next_st.wr = 1'b1;
						next_st.wr_data = st.shreg;
					end
					if (cfg_in.crc_enable && !st.sof_fault && ((st.byte_cnt < crc_min) || !crc_ok_in))
						next_st.err.crc_error_flag = 1'b1;
				end

				// Illegal code back to idle
				default:
				begin
					next_st.fsm = CRF_IDLE;
				end
			endcase
		end
		// Host write of the alignment field
		if (align_load_in && (st.fsm == CRF_IDLE))
			next_st.align = align_value_in;
	end

	// Register the whole state
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			st <= '0;
			st.fsm <= CRF_IDLE;
			st.align <= `CRF_ALIGN_RESET;
		end
		else
			st <= next_st;
	end

	// ==========================================
	// Modem state encoding
	always_comb
	begin
		case (st.fsm)
			CRF_IDLE: modem_state_field_out = `CRF_MS_IDLE;
			CRF_TX_SOF: modem_state_field_out = `CRF_MS_TX_SOF;
			CRF_TX_DATA: modem_state_field_out = `CRF_MS_TX_DATA;
			CRF_TX_EOF: modem_state_field_out = `CRF_MS_TX_EOF;
			CRF_GO_RX_START: modem_state_field_out = `CRF_MS_TRANSITION;
			CRF_GO_RX_FINISH: modem_state_field_out = `CRF_MS_TRANSITION;
			CRF_RX_DELAY: modem_state_field_out = `CRF_MS_RX_WAIT;
			CRF_AWAIT: modem_state_field_out = `CRF_MS_AWAIT;
			CRF_RECEIVING: modem_state_field_out = `CRF_MS_RECEIVING;
			default: modem_state_field_out = `CRF_MS_IDLE;
		endcase
	end

	// ==========================================
	// Registered outputs
	assign fifo_wr_out = st.wr;
	assign fifo_data_out = st.wr_data;
	assign rx_done_out = st.done;
	assign err_out = st.err;
	assign collision_position_out = st.coll_pos;
	assign last_byte_valid_bits_out = st.last_bits;
	assign receive_alignment_offset_out = st.align;
endmodule

//--- design/crf_cfg.svh
// Purpose: Constants of the contactless receive framing block
// Assumes: Included by bare name; definitions only
// Notes: Offsets, fields and counts as `define macros
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
`define CRF_CMD_IDLE 6'h00
`define CRF_CMD_TRANSCEIVE 6'h1e
`define CRF_SOF_TICKS 8'h01
`define CRF_EOF_TICKS 8'h01
`define CRF_MS_IDLE 3'h0
`define CRF_MS_TX_SOF 3'h1
`define CRF_MS_TX_DATA 3'h2
`define CRF_MS_TX_EOF 3'h3
`define CRF_MS_TRANSITION 3'h4
`define CRF_MS_RX_WAIT 3'h5
`define CRF_MS_AWAIT 3'h6
`define CRF_MS_RECEIVING 3'h7
`define CRF_SOF_POSITION 8'h00
`define CRF_ALIGN_SUPPRESS 3'h7
`define CRF_ALIGN_RESET 3'h0
`endif

//--- design/crf_pkg.sv
// Purpose: Types of the contactless receive framing block
// Assumes: Constants live in crf_cfg.svh
// Notes: One-hot sequencer states and port carriers
package crf_pkg;
	typedef enum logic [8:0] {
		CRF_IDLE = 9'h001,
		CRF_TX_SOF = 9'h002,
		CRF_TX_DATA = 9'h004,
		CRF_TX_EOF = 9'h008,
		CRF_GO_RX_START = 9'h010,
		CRF_RX_DELAY = 9'h020,
		CRF_AWAIT = 9'h040,
		CRF_RECEIVING = 9'h080,
		CRF_GO_RX_FINISH = 9'h100
	} crf_state_t;
	// One decoded Manchester symbol from the demodulator
	typedef struct packed {
		logic valid;
		logic is_sof;
		logic end_of_stream;
		logic [3:0] amp_first;
		logic [3:0] amp_second;
	} crf_sym_t;
	// Static settings from the host
	typedef struct packed {
		logic [3:0] collision_level_threshold;
		logic zero_after_collision_option;
		logic parity_enable;
		logic odd_parity_select;
		logic crc_enable;
		logic crc_two_bytes;
		logic [7:0] receive_wait_delay;
		logic [3:0] tx_rx_phase_setting;
	} crf_cfg_t;
	typedef struct packed {
		logic framing_error_flag;
		logic crc_error_flag;
		logic parity_error_flag;
		logic collision_error_flag;
	} crf_err_t;
endpackage

//--- design/crf_countdown.sv
// Purpose: Loadable down-counter giving a done pulse
// Assumes: Load and tick from the same clock
// Notes: Done is high one cycle once count reaches zero
`timescale 1ns/1ns
module crf_countdown
	import crf_pkg::*;
#(
	parameter int WIDTH = 8
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] value_in,
	input wire logic tick_in,
	output logic done_out
);
	typedef struct packed {
		logic armed;
		logic [WIDTH-1:0] cnt;
	} crf_cd_t;
	crf_cd_t st;
	crf_cd_t next_st;
	// ==========================================
	// Count down on tick while armed
	always_comb
	begin
		next_st = st;
		if (load_in)
		begin
			next_st.armed = 1'b1;
			next_st.cnt = value_in;
		end
		else if (st.armed && (st.cnt == '0))
			next_st.armed = 1'b0;
		else if (st.armed && tick_in)
			next_st.cnt = st.cnt - 1'b1;
	end
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
			st <= '0;
		else
			st <= next_st;
	end
	// Done while armed at zero
	assign done_out = st.armed && (st.cnt == '0) && !load_in;
endmodule

//--- tb/crf_rx_framer_chk.sv
// Purpose: Port checker of the receive framer
// Assumes: Bit ticks spaced wider than phase plus one
// Notes: Bound at the foot of this file
`timescale 1ns/1ns
module crf_rx_framer_chk
	import crf_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic bit_tick_in,
	input wire logic cmd_valid_in,
	input wire logic [5:0] cmd_code_in,
	input wire crf_cfg_t cfg_in,
	input wire crf_sym_t sym_in,
	input wire crf_err_t err_out,
	input wire logic rx_done_out,
	input wire logic [2:0] receive_alignment_offset_out,
	input wire logic [2:0] modem_state_field_out,
	input wire logic rx_sample_tick_out
);
	logic [4:0] since;
	logic hit;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// Cycles since last tick; colliding symbol
	always_ff @(posedge clk_in)
		since <= bit_tick_in ? 5'h01 : since + {4'h0, since != 5'h1f};
	assign hit = sym_in.valid && modem_state_field_out[2:1] == 2'h3
		&& sym_in.amp_first > cfg_in.collision_level_threshold
		&& sym_in.amp_second > cfg_in.collision_level_threshold;
	// ====
	// Checks
	property p_start;
		modem_state_field_out == 3'h0 && cmd_valid_in && cmd_code_in == 6'h1e |=> modem_state_field_out == 3'h1;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_tx;
		modem_state_field_out == 3'h1 && bit_tick_in && !cmd_valid_in |=> modem_state_field_out == 3'h2;
	endproperty
	a_tx: assert property (p_tx) else $error("no data phase");
	property p_wait;
		$rose(modem_state_field_out == 3'h6) |-> $past(modem_state_field_out) == 3'h5;
	endproperty
	a_wait: assert property (p_wait) else $error("wait skipped");
	property p_done;
		rx_done_out |-> modem_state_field_out == 3'h0 && $past(modem_state_field_out) == 3'h4;
	endproperty
	a_done: assert property (p_done) else $error("bad finish");
	property p_align;
		rx_done_out |-> receive_alignment_offset_out == 3'h0;
	endproperty
	a_align: assert property (p_align) else $error("offset kept");
	property p_coll;
		hit && !cmd_valid_in |=> err_out.collision_error_flag;
	endproperty
	a_coll: assert property (p_coll) else $error("collision missed");
	property p_cause;
		$rose(err_out.collision_error_flag) |-> $past(hit);
	endproperty
	a_cause: assert property (p_cause) else $error("false collision");
	property p_phase;
		rx_sample_tick_out |-> since == {1'b0, cfg_in.tx_rx_phase_setting} + 5'h01;
	endproperty
	a_phase: assert property (p_phase) else $error("phase off");
endmodule
bind crf_rx_framer crf_rx_framer_chk chk (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.bit_tick_in(bit_tick_in),
	.cmd_valid_in(cmd_valid_in),
	.cmd_code_in(cmd_code_in),
	.cfg_in(cfg_in),
	.sym_in(sym_in),
	.err_out(err_out),
	.rx_done_out(rx_done_out),
	.receive_alignment_offset_out(receive_alignment_offset_out),
	.modem_state_field_out(modem_state_field_out),
	.rx_sample_tick_out(rx_sample_tick_out)
);

//--- tb/crf_card_model.sv
// Purpose: Card answering with Manchester symbols
// Assumes: Symbols change at falling edges
// Notes: Idle lines carry a moving pattern
`timescale 1ns/1ns
module crf_card_model
	import crf_pkg::*;
(
	input wire logic clk_in,
	output crf_sym_t sym_out
);
	crf_sym_t cur = '0;
	logic [7:0] noise = 8'h5a;
	// Released line toggles every cycle
	always @(negedge clk_in)
		noise <= ~noise;
	assign sym_out = cur.valid ? cur : {3'h0, noise};
	// One symbol: 0 zero, 1 one, 2 both halves
	task automatic put(input logic [1:0] k, input logic sof, input logic eos, input int gap);
		@(negedge clk_in);
		cur = {1'b1, sof, eos, k == 2'h0 ? 4'h1 : 4'hc, k == 2'h1 ? 4'h1 : 4'hc};
		@(negedge clk_in);
		cur = '0;
		repeat (gap) @(negedge clk_in);
	endtask
	// Frame of n bits, LSB first; sk 3 omits the start
	task automatic frame(input logic [1:0] sk, input logic [31:0] v, input logic [31:0] c, input int n,
		input int gap);
		if (sk != 2'h3)
			put(sk, 1'b1, 1'b0, gap);
		for (int i = 0; i < n; i++)
			put(c[i] ? 2'h2 : {1'b0, v[i]}, 1'b0, 1'b0, gap);
		put(2'h0, 1'b0, 1'b1, gap);
	endtask
endmodule

//--- tb/testbench.sv
// Purpose: Self-checking bench of the receive framer
// Assumes: Bit tick every fourth cycle
// Notes: Card model supplies the reply frames
`timescale 1ns/1ns
module testbench;
	import crf_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic tick = 1'b0;
	logic cv = 1'b0;
	logic al = 1'b0;
	logic dn = 1'b0;
	logic [1:0] tc = 2'h0;
	logic [5:0] cc = 6'h00;
	logic [2:0] av = 3'h0;
	crf_cfg_t cfg = '0;
	crf_sym_t sym;
	crf_err_t err;
	logic wr, done;
	logic [7:0] fd, pos;
	logic [2:0] lb, ao, ms;
	logic [7:0] q[$];
	int mismatches = 0;
	int cmp_count = 0;
	crf_rx_framer uut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.bit_tick_in(tick),
		.cmd_valid_in(cv),
		.cmd_code_in(cc),
		.cfg_in(cfg),
		.tx_bits_in(8'h02),
		.align_load_in(al),
		.align_value_in(av),
		.sym_in(sym),
		.crc_ok_in(1'b1),
		.fifo_wr_out(wr),
		.fifo_data_out(fd),
		.rx_done_out(done),
		.err_out(err),
		.collision_position_out(pos),
		.last_byte_valid_bits_out(lb),
		.receive_alignment_offset_out(ao),
		.modem_state_field_out(ms),
		.rx_sample_tick_out()
	);
	crf_card_model card (
		.clk_in(clk_in),
		.sym_out(sym)
	);
	// ====
	// Clock, bit tick and capture
	initial
	begin
		forever #10 clk_in = ~clk_in;
	end
	always @(negedge clk_in)
	begin
		tc <= tc + 2'h1;
		tick <= tc == 2'h3;
	end
	always @(posedge clk_in)
	begin
		if (wr === 1'b1)
			q.push_back(fd);
		if (done === 1'b1)
			dn <= 1'b1;
	end
	// ====
	// Tasks
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic cmd(input logic [5:0] c);
		@(negedge clk_in);
		cv = 1'b1;
		cc = c;
		@(negedge clk_in);
		cv = 1'b0;
	endtask
	task automatic align(input logic [2:0] v);
		@(negedge clk_in);
		al = 1'b1;
		av = v;
		@(negedge clk_in);
		al = 1'b0;
		chk("ao", {5'h00, v}, {5'h00, ao});
	endtask
	task automatic hold(input logic [2:0] s);
		int n;
		n = 0;
		while (ms !== s && n < 400)
		begin
			@(negedge clk_in);
			n++;
		end
		if (n == 400)
		begin
			chk("wait", {5'h00, s}, {5'h00, ms});
			close_out();
		end
	endtask
	task automatic run(input logic [1:0] sk, input logic [31:0] v, input logic [31:0] c, input int n, input int g);
		q.delete();
		dn = 1'b0;
		cmd(6'h1e);
		hold(3'h6);
		card.frame(sk, v, c, n, g);
		hold(3'h0);
		@(negedge clk_in);
		chk("done", 8'h01, {7'h00, dn});
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ====
	// Scenarios
	initial
	begin
		cfg.collision_level_threshold = 4'h6;
		cfg.parity_enable = 1'b1;
		cfg.odd_parity_select = 1'b1;
		cfg.receive_wait_delay = 8'h01;
		cfg.tx_rx_phase_setting = 4'h2;
		repeat (8) @(negedge clk_in);
		rst_n_in = 1'b1;
		chk("ms", 8'h00, {5'h00, ms});
		run(2'h0, {1'b0, 8'h00, 1'b1, 8'h96}, 32'h0002_1000, 18, 0);
		chk("b0", 8'h96, q[0]);
		chk("b1", 8'h08, q[1]);
		chk("err", 8'h03, {4'h0, err});
		chk("pos", 8'h0c, pos);
		cfg.zero_after_collision_option = 1'b1;
		run(2'h0, {1'b0, 8'hff, 1'b1, 8'h5a}, 32'h0000_4400, 18, 3);
		chk("b1", 8'h03, q[1]);
		chk("err", 8'h01, {4'h0, err});
		chk("pos", 8'h0a, pos);
		run(2'h2, 32'hff, 32'h0, 8, 1);
		chk("cnt", 8'h00, 8'(q.size()));
		chk("err", 8'h09, {4'h0, err});
		chk("pos", 8'h00, pos);
		run(2'h3, 32'hff, 32'h0, 8, 0);
		chk("err", 8'h08, {4'h0, err});
		// Last-bit count left unchecked under framing error
		cfg.zero_after_collision_option = 1'b0;
		cfg.crc_enable = 1'b1;
		align(3'h3);
		run(2'h0, {2'h3, 1'b1, 8'h81, 1'b0, 5'h16}, 32'h0, 17, 0);
		chk("b0", 8'hb0, q[0]);
		chk("b2", 8'h03, q[2]);
		chk("lb", 8'h02, {5'h00, lb});
		chk("err", 8'h00, {4'h0, err});
		chk("ao", 8'h00, {5'h00, ao});
		cfg.parity_enable = 1'b0;
		align(3'h7);
		run(2'h0, 32'h1, 32'h0, 1, 0);
		chk("cnt", 8'h00, 8'(q.size()));
		chk("err", 8'h04, {4'h0, err});
		cfg.parity_enable = 1'b1;
		cfg.odd_parity_select = 1'b0;
		cfg.crc_two_bytes = 1'b1;
		run(2'h0, {23'h0, 1'b0, 8'h96}, 32'h0, 9, 0);
		chk("b0", 8'h96, q[0]);
		chk("err", 8'h04, {4'h0, err});
		cmd(6'h1e);
		cmd(6'h00);
		chk("ms", 8'h00, {5'h00, ms});
		close_out();
	end
endmodule
